// ### src/dtec_pkg.sv
// Purpose: shared constants and types for the dual timer/event counter
// Assumes: 32-bit APB, one word per register, byte address = index * 4
// Notes:   state types are used by the main counter module and the edge synchroniser
package dtec_pkg;

  // ----------------------------------------------------------------
  // register indices and address width
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_T0_COUNT  = 6'h0D;
  localparam logic [5:0] IDX_T0_CTRL   = 6'h0E;
  localparam logic [5:0] IDX_T1_HIGH   = 6'h0F;
  localparam logic [5:0] IDX_T1_LOW    = 6'h10;
  localparam logic [5:0] IDX_T1_CTRL   = 6'h11;
  localparam logic [5:0] IDX_STATUS    = 6'h12;
  localparam int         ADDR_W        = 8;

  // ----------------------------------------------------------------
  // control field positions and masks
  // ----------------------------------------------------------------
  localparam int         CTL_MODE_HI   = 7;
  localparam int         CTL_MODE_LO   = 6;
  localparam int         CTL_T1_CLKSEL = 5;
  localparam int         CTL_ENABLE    = 4;
  localparam int         CTL_EDGE      = 3;
  localparam int         ST_T0_FLAG    = 0;
  localparam int         ST_T1_FLAG    = 1;
  localparam logic [7:0] T0_CTL_MASK   = 8'hDF;
  localparam logic [7:0] T1_CTL_MASK   = 8'hF8;

  // ----------------------------------------------------------------
  // mode encodings and values after reset
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_UNUSED   = 2'h0;
  localparam logic [1:0] MODE_EVENT    = 2'h1;
  localparam logic [1:0] MODE_TIMER    = 2'h2;
  localparam logic [1:0] MODE_PULSE    = 2'h3;
  localparam logic [7:0] T0_CTL_RST    = 8'h08;
  localparam logic [7:0] T1_CTL_RST    = 8'h08;
  localparam logic [7:0]  T0_MAX       = 8'hFF;
  localparam logic [15:0] T1_MAX       = 16'hFFFF;
  localparam int         PRESC_W       = 7;
  localparam logic [1:0] DIV4_MASK     = 2'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic {
    PW_WAIT,
    PW_MEAS
  } dtec_pw_t;

  typedef struct packed {
    logic [7:0]         t0_cnt;
    logic [7:0]         t0_pre;
    logic [7:0]         t0_ctl;
    dtec_pw_t           t0_pw;
    logic [15:0]        t1_cnt;
    logic [15:0]        t1_pre;
    logic [7:0]         t1_ctl;
    logic [7:0]         t1_lowbuf;
    dtec_pw_t           t1_pw;
    logic [PRESC_W-1:0] presc;
    logic               t0_flag;
    logic               t1_flag;
    logic               t0_ovf;
    logic               t1_ovf;
    logic               t0_tog;
    logic               t1_tog;
    logic [31:0]        rdata;
  } dtec_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } dtec_sync_t;

endpackage

// ### src/dtec_edge_sync.sv
// Purpose: bring one pin into the pclk domain and find its edges
// Assumes: pin changes slower than two pclk periods
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module dtec_edge_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  dtec_pkg::dtec_sync_t r;
  dtec_pkg::dtec_sync_t n;

  // ----------------------------------------------------------------
  // two-stage synchroniser plus one history stage
  // ----------------------------------------------------------------
  always_comb begin
    n    = r;
    n.s1 = pin_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // edges compare the settled stages only
  assign level = r.s2;
  assign rise  = r.s2 & ~r.s3;
  assign fall  = ~r.s2 & r.s3;

endmodule

// ### src/dtec_timer.sv
// Purpose: 8-bit and 16-bit timer/event counters behind an APB slave
// Assumes: pclk is the system clock; pins and 32 kHz clock are async
// Notes:   zero-wait APB; read data is captured in the setup cycle
//
// Overview of operation
// - counter zero is 8-bit up counter on prescaled clock or pin
// - counter one is 16-bit up counter on pin, clock/4 or 32 kHz
// - counter one control bit 5 picks clock/4 (0) or 32 kHz (1)
// - counter zero data: write sets preload, read returns live count
// - counter one low-byte write only fills the low-byte buffer
// - high-byte write moves byte plus buffer in; preload always updated
// - high-byte read captures low count into buffer; low read returns it
// - control bits 7:6 pick mode: 01 event, 10 timer, 11 pulse
// - control bit 3 picks pin edge: 0 rising, 1 falling
// - timer mode counts the internal clock, not the pin
// - event and timer modes count up to FFH or FFFFH
// - overflow reloads from preload and raises the overflow flag
// - pulse mode: start on edge, count while level holds, stop on return
// - after one pulse the enable clears; result held until re-enabled
// - pulse measurement starts on an edge, not on a level
// - overflow in pulse mode also reloads and flags
// - control bit 4 enables; hardware never clears it outside pulse mode
// - counter zero bits 2:0 divide system clock by two to the power n
// - overflow drives a wake-up pulse and the divider output source
// - unused control bits read as zero
// - preload write while off also loads the counter
// - counting is blocked while software reads a count
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module dtec_timer (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [dtec_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       t0_pin,
  input  wire logic                       t1_pin,
  input  wire logic                       clk_32k_in,
  output logic                            t0_overflow_pulse,
  output logic                            t1_overflow_pulse,
  output logic                            t0_freq_div_out,
  output logic                            t1_freq_div_out,
  output logic                            t0_overflow_flag,
  output logic                            t1_overflow_flag
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // prescaler tap: one pulse every 2**sel cycles
  function automatic logic presc_tick(
    input logic [dtec_pkg::PRESC_W-1:0] cnt,
    input logic [2:0]                   sel
  );
    logic [dtec_pkg::PRESC_W-1:0] mask;
    mask = 7'h7F >> (3'h7 - sel);
    return (cnt & mask) == mask;
  endfunction

  // count enable for one counter from its mode
  function automatic logic count_tick(
    input logic [1:0] mode,
    input logic       en,
    input logic       meas,
    input logic       act_edge,
    input logic       int_tick
  );
    logic t;
    t = 1'b0;
    case (mode)
      dtec_pkg::MODE_EVENT: t = en & act_edge;
      dtec_pkg::MODE_TIMER: t = en & int_tick;
      dtec_pkg::MODE_PULSE: t = en & meas & int_tick;
      default:              t = 1'b0;
    endcase
    return t;
  endfunction

  // ----------------------------------------------------------------
  // state and pin conditioning
  // ----------------------------------------------------------------
  dtec_pkg::dtec_state_t r;
  dtec_pkg::dtec_state_t n;

  logic t0_lvl;
  logic t0_rise;
  logic t0_fall;
  logic t1_lvl;
  logic t1_rise;
  logic t1_fall;
  logic k32_rise;

  // each asynchronous input passes a synchroniser first
  dtec_edge_sync u_sync_t0 (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (t0_pin),
    .level   (t0_lvl),
    .rise    (t0_rise),
    .fall    (t0_fall)
  );

  dtec_edge_sync u_sync_t1 (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (t1_pin),
    .level   (t1_lvl),
    .rise    (t1_rise),
    .fall    (t1_fall)
  );

  // the 32 kHz clock is sampled, so it is no second domain
  // its edges lie hundreds of pclk cycles apart, far above the sync limit
  dtec_edge_sync u_sync_32k (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (clk_32k_in),
    .level   (),
    .rise    (k32_rise),
    .fall    ()
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [5:0] idx;
  logic       hit;
  logic       setup_rd;
  logic       acc;
  logic       wr;
  logic       rd;

  assign idx      = paddr[7:2];
  assign hit      = (paddr[1:0] == 2'h0) &&
                    (idx >= dtec_pkg::IDX_T0_COUNT) &&
                    (idx <= dtec_pkg::IDX_STATUS);
  assign setup_rd = psel & ~penable & ~pwrite;
  assign acc      = psel & penable & hit;
  assign wr       = acc & pwrite;
  assign rd       = acc & ~pwrite;

  // zero wait states; unmapped words answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // ----------------------------------------------------------------
  // counter control decode
  // ----------------------------------------------------------------
  logic [1:0] t0_mode;
  logic [1:0] t1_mode;
  logic       t0_en;
  logic       t1_en;
  logic       t0_act;
  logic       t0_inact;
  logic       t1_act;
  logic       t1_inact;
  logic       t0_itick;
  logic       t1_itick;
  logic       t0_blk;
  logic       t1_blk;
  logic       t0_tick;
  logic       t1_tick;

  assign t0_mode = r.t0_ctl[dtec_pkg::CTL_MODE_HI:dtec_pkg::CTL_MODE_LO];
  assign t1_mode = r.t1_ctl[dtec_pkg::CTL_MODE_HI:dtec_pkg::CTL_MODE_LO];
  assign t0_en   = r.t0_ctl[dtec_pkg::CTL_ENABLE];
  assign t1_en   = r.t1_ctl[dtec_pkg::CTL_ENABLE];

  // edge select: 0 counts rising, 1 counts falling
  assign t0_act   = r.t0_ctl[dtec_pkg::CTL_EDGE] ? t0_fall : t0_rise;
  assign t0_inact = r.t0_ctl[dtec_pkg::CTL_EDGE] ? t0_rise : t0_fall;
  assign t1_act   = r.t1_ctl[dtec_pkg::CTL_EDGE] ? t1_fall : t1_rise;
  assign t1_inact = r.t1_ctl[dtec_pkg::CTL_EDGE] ? t1_rise : t1_fall;

  // internal clocks as enables on pclk
  assign t0_itick = presc_tick(r.presc, r.t0_ctl[2:0]);
  assign t1_itick = r.t1_ctl[dtec_pkg::CTL_T1_CLKSEL] ? k32_rise
                  : (r.presc[1:0] == dtec_pkg::DIV4_MASK);

  // a count read freezes the counter for setup and access cycles
  // trade-off: ticks are dropped, not stretched, so a loop that polls
  // the count very often will see the counter run measurably slow
  assign t0_blk = psel & ~pwrite & hit & (idx == dtec_pkg::IDX_T0_COUNT);
  assign t1_blk = psel & ~pwrite & hit & ((idx == dtec_pkg::IDX_T1_HIGH) ||
                  (idx == dtec_pkg::IDX_T1_LOW));

  assign t0_tick = count_tick(t0_mode, t0_en, r.t0_pw == dtec_pkg::PW_MEAS,
                              t0_act, t0_itick) & ~t0_blk;
  assign t1_tick = count_tick(t1_mode, t1_en, r.t1_pw == dtec_pkg::PW_MEAS,
                              t1_act, t1_itick) & ~t1_blk;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n        = r;
    n.t0_ovf = 1'b0;
    n.t1_ovf = 1'b0;
    // prescaler free-runs and is shared; control writes never restart it
    n.presc  = r.presc + 7'h01;

    // pulse width sequencer, counter zero
    // the opposite edge ends a measurement; the result then stays put
    if ((t0_mode == dtec_pkg::MODE_PULSE) && t0_en) begin
      if ((r.t0_pw == dtec_pkg::PW_WAIT) && t0_act) begin
        n.t0_pw = dtec_pkg::PW_MEAS;
      end else if ((r.t0_pw == dtec_pkg::PW_MEAS) && t0_inact) begin
        n.t0_pw = dtec_pkg::PW_WAIT;
        n.t0_ctl[dtec_pkg::CTL_ENABLE] = 1'b0;
      end
    end else begin
      n.t0_pw = dtec_pkg::PW_WAIT;
    end

    // pulse width sequencer, counter one
    if ((t1_mode == dtec_pkg::MODE_PULSE) && t1_en) begin
      if ((r.t1_pw == dtec_pkg::PW_WAIT) && t1_act) begin
        n.t1_pw = dtec_pkg::PW_MEAS;
      end else if ((r.t1_pw == dtec_pkg::PW_MEAS) && t1_inact) begin
        n.t1_pw = dtec_pkg::PW_WAIT;
        n.t1_ctl[dtec_pkg::CTL_ENABLE] = 1'b0;
      end
    end else begin
      n.t1_pw = dtec_pkg::PW_WAIT;
    end

    // counter zero increment with reload on overflow, any mode
    if (t0_tick) begin
      if (r.t0_cnt == dtec_pkg::T0_MAX) begin
        n.t0_cnt = r.t0_pre;
        n.t0_ovf = 1'b1;
        n.t0_tog = ~r.t0_tog;
      end else begin
        n.t0_cnt = r.t0_cnt + 8'h01;
      end
    end

    // counter one increment with reload on overflow, any mode
    if (t1_tick) begin
      if (r.t1_cnt == dtec_pkg::T1_MAX) begin
        n.t1_cnt = r.t1_pre;
        n.t1_ovf = 1'b1;
        n.t1_tog = ~r.t1_tog;
      end else begin
        n.t1_cnt = r.t1_cnt + 16'h0001;
      end
    end

    // read data is latched in the setup cycle, valid in access
    if (setup_rd) begin
      n.rdata = 32'h0000_0000;
      case (idx)
        dtec_pkg::IDX_T0_COUNT: n.rdata[7:0] = r.t0_cnt;
        dtec_pkg::IDX_T0_CTRL:  n.rdata[7:0] = r.t0_ctl & dtec_pkg::T0_CTL_MASK;
        dtec_pkg::IDX_T1_HIGH:  n.rdata[7:0] = r.t1_cnt[15:8];
        dtec_pkg::IDX_T1_LOW:   n.rdata[7:0] = r.t1_lowbuf;
        dtec_pkg::IDX_T1_CTRL:  n.rdata[7:0] = r.t1_ctl & dtec_pkg::T1_CTL_MASK;
        dtec_pkg::IDX_STATUS: begin
          n.rdata[dtec_pkg::ST_T0_FLAG] = r.t0_flag;
          n.rdata[dtec_pkg::ST_T1_FLAG] = r.t1_flag;
        end
        default:                n.rdata = 32'h0000_0000;
      endcase
    end

    // refused reads answer zero rather than a stale or misaligned word
    if (setup_rd && !hit) begin
      n.rdata = 32'h0000_0000;
    end

    // high-byte read: low half goes to the buffer, counter still blocked
    if (rd && (idx == dtec_pkg::IDX_T1_HIGH)) begin
      n.t1_lowbuf = r.t1_cnt[7:0];
    end

    // software writes override hardware updates of the same cycle, except flag clears, where a new overflow wins
    if (wr) begin
      case (idx)
        dtec_pkg::IDX_T0_COUNT: begin
          n.t0_pre = pwdata[7:0];
          if (!t0_en) begin
            n.t0_cnt = pwdata[7:0];
          end
        end
        dtec_pkg::IDX_T0_CTRL: begin
          n.t0_ctl = pwdata[7:0] & dtec_pkg::T0_CTL_MASK;
          n.t0_pw  = dtec_pkg::PW_WAIT;
        end
        dtec_pkg::IDX_T1_HIGH: begin
          n.t1_pre = {pwdata[7:0], r.t1_lowbuf};
          if (!t1_en) begin
            n.t1_cnt = {pwdata[7:0], r.t1_lowbuf};
          end
        end
        dtec_pkg::IDX_T1_LOW: begin
          n.t1_lowbuf = pwdata[7:0];
        end
        dtec_pkg::IDX_T1_CTRL: begin
          n.t1_ctl = pwdata[7:0] & dtec_pkg::T1_CTL_MASK;
          n.t1_pw  = dtec_pkg::PW_WAIT;
        end
        // the status index only clears flags, handled after this case
        default: begin
          n.t0_flag = r.t0_flag;
        end
      endcase
    end

    // sticky flags: write one clears, a new overflow wins over the clear
    n.t0_flag = (r.t0_flag & ~(wr && (idx == dtec_pkg::IDX_STATUS) &&
                 pwdata[dtec_pkg::ST_T0_FLAG])) | n.t0_ovf;
    n.t1_flag = (r.t1_flag & ~(wr && (idx == dtec_pkg::IDX_STATUS) &&
                 pwdata[dtec_pkg::ST_T1_FLAG])) | n.t1_ovf;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // controls start with falling-edge select set, all else zero
      r        <= '0;
      r.t0_ctl <= dtec_pkg::T0_CTL_RST;
      r.t1_ctl <= dtec_pkg::T1_CTL_RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign prdata            = r.rdata;
  assign t0_overflow_pulse = r.t0_ovf;
  assign t1_overflow_pulse = r.t1_ovf;
  // divider sources toggle per overflow, so they run at half that rate
  assign t0_freq_div_out   = r.t0_tog;
  assign t1_freq_div_out   = r.t1_tog;
  assign t0_overflow_flag  = r.t0_flag;
  assign t1_overflow_flag  = r.t1_flag;

endmodule

// ### sim/dtec_timer_chk.sv
// Purpose: port-level checks for the dual timer/event counter
// Assumes: registered overflow outputs, zero-wait APB
// Notes:   bound into every dtec_timer instance
`timescale 1ns/100ps
module dtec_timer_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        t0_overflow_pulse,
  input wire logic        t1_overflow_pulse,
  input wire logic        t0_freq_div_out,
  input wire logic        t1_freq_div_out,
  input wire logic        t0_overflow_flag,
  input wire logic        t1_overflow_flag
);
  // ------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_acc;
  logic clr_wr;
  // refused accesses carry no register data, so leave them out
  assign rd_acc = psel && penable && !pwrite && !pslverr;
  assign clr_wr = psel && penable && pwrite && paddr == {dtec_pkg::IDX_STATUS, 2'h0};

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_T0_CTL_RSVD: assert property (rd_acc && paddr[7:2] == dtec_pkg::IDX_T0_CTRL |-> !prdata[5])
    else $error("t0 control unused bit read as one");
  AST_T1_CTL_RSVD: assert property (rd_acc && paddr[7:2] == dtec_pkg::IDX_T1_CTRL |-> prdata[2:0] == 3'h0)
    else $error("t1 control unused bits read nonzero");
  AST_T0_FLAG_SET: assert property ($rose(t0_overflow_flag) |-> t0_overflow_pulse)
    else $error("t0 flag rose without overflow");
  AST_T1_FLAG_SET: assert property ($rose(t1_overflow_flag) |-> t1_overflow_pulse)
    else $error("t1 flag rose without overflow");
  AST_T0_FLAG_HOLD: assert property (t0_overflow_flag && !(clr_wr && pwdata[0]) |=> t0_overflow_flag)
    else $error("t0 flag dropped without clear");
  AST_T1_FLAG_CLR: assert property (clr_wr && pwdata[1] ##1 !t1_overflow_pulse |-> !t1_overflow_flag)
    else $error("t1 flag survived its clear");
  AST_T0_PFD: assert property ($changed(t0_freq_div_out) |-> t0_overflow_pulse)
    else $error("t0 divider output moved without overflow");
  AST_T1_PFD: assert property ($changed(t1_freq_div_out) |-> t1_overflow_pulse)
    else $error("t1 divider output moved without overflow");
  // main scenarios reached
  cover property (t0_overflow_pulse);
  cover property (t1_overflow_pulse);
  cover property (clr_wr && pwdata[0] && t0_overflow_flag);
endmodule

bind dtec_timer dtec_timer_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pslverr, .t0_overflow_pulse, .t1_overflow_pulse, .t0_freq_div_out, .t1_freq_div_out, .t0_overflow_flag,
  .t1_overflow_flag);

// ### sim/dtec_pin_model.sv
// Purpose: far side of the counters: count/measure pins and 32 kHz clock
// Assumes: pclk period 100 ns
// Notes:   pins move on pclk edges, then rest three cycles
`timescale 1ns/100ps
module dtec_pin_model (
  input wire logic pclk,
  output logic     t0_pin,
  output logic     t1_pin,
  output logic     clk_32k_in
);
  // crystal clock runs free, unrelated to pclk
  initial begin
    t0_pin = 1'b0;
    t1_pin = 1'b0;
    clk_32k_in = 1'b0;
    forever #15258.8 clk_32k_in = ~clk_32k_in;
  end

  // one pin step; the rest keeps edges apart for the synchroniser
  task automatic set_pin(input int ch, input logic lvl);
    @(posedge pclk);
    if (ch == 0) t0_pin <= lvl;
    else t1_pin <= lvl;
    repeat (3) @(posedge pclk);
  endtask

  // high pulse held w extra cycles, then back low
  task automatic pulse_hi(input int ch, input int w);
    set_pin(ch, 1'b1);
    repeat (w) @(posedge pclk);
    set_pin(ch, 1'b0);
  endtask
endmodule

// ### sim/dtec_timer_tb_top.sv
// Purpose: self-checking bench for the dual timer/event counter
// Assumes: 10 MHz pclk, zero-wait APB, pin model on the far side
// Notes:   random preloads and control values from a fixed seed
`timescale 1ns/100ps
module dtec_timer_tb_top;
  localparam logic [7:0] A_T0  = {dtec_pkg::IDX_T0_COUNT, 2'h0};
  localparam logic [7:0] A_C0  = {dtec_pkg::IDX_T0_CTRL, 2'h0};
  localparam logic [7:0] A_T1H = {dtec_pkg::IDX_T1_HIGH, 2'h0};
  localparam logic [7:0] A_T1L = {dtec_pkg::IDX_T1_LOW, 2'h0};
  localparam logic [7:0] A_C1  = {dtec_pkg::IDX_T1_CTRL, 2'h0};
  localparam logic [7:0] A_ST  = {dtec_pkg::IDX_STATUS, 2'h0};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        t0_pin, t1_pin, clk_32k_in, t0_overflow_pulse, t1_overflow_pulse;
  logic        t0_freq_div_out, t1_freq_div_out, t0_overflow_flag, t1_overflow_flag;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v, hi;
  int          num_errors, checks, seed, c, e, i, n;

  dtec_timer dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .t0_pin, .t1_pin, .clk_32k_in, .t0_overflow_pulse, .t1_overflow_pulse, .t0_freq_div_out,
    .t1_freq_div_out, .t0_overflow_flag, .t1_overflow_flag);
  dtec_pin_model pin_u (.pclk, .t0_pin, .t1_pin, .clk_32k_in);

  // ------------------------------------------------------------
  // clock, compares and bus tasks
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chkb(input string nm, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // one APB transfer, entered just after a rising edge; idles one cycle after
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [7:0] ca(input int ch);
    return ch ? A_C1 : A_C0;
  endfunction

  // control readback: unused bits come back as zero
  function automatic logic [31:0] exp_ctl(input int ch, input logic [31:0] w);
    return w & (ch ? 32'hF8 : 32'hDF);
  endfunction

  // counter one goes low byte first on write, high byte first on read
  task automatic wrcnt(input int ch, input logic [15:0] d);
    if (ch == 0) apb(1'b1, A_T0, {24'h0, d[7:0]});
    else begin
      apb(1'b1, A_T1L, {24'h0, d[7:0]});
      apb(1'b1, A_T1H, {24'h0, d[15:8]});
    end
  endtask

  task automatic rdcnt(input int ch);
    if (ch == 0) apb(1'b0, A_T0, 32'h0);
    else begin
      apb(1'b0, A_T1H, 32'h0);
      hi = rd;
      apb(1'b0, A_T1L, 32'h0);
      rd = {16'h0, hi[7:0], rd[7:0]};
    end
  endtask

  // cycles up to the next overflow pulse, bounded
  task automatic span(input int ch, output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while ((ch ? t1_overflow_pulse : t0_overflow_pulse) !== 1'b1 && k < 4000);
    if (k >= 4000) num_errors++;
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    seed = 85608;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chkb("unmapped_err", 1'b1, err);
    apb(1'b1, 8'h35, 32'hFF);
    chkb("misaligned_err", 1'b1, err);
    // random control values with enable off; unused bits must read zero
    for (i = 0; i < 8; i++) begin
      v = $random(seed) & 32'hEF;
      apb(1'b1, ca(i % 2), v);
      apb(1'b0, ca(i % 2), 32'h0);
      chk("ctl_readback", exp_ctl(i % 2, v), rd);
    end
    // preload while off also loads; a lone low-byte write changes nothing
    for (c = 0; c < 2; c++) begin
      v = $random(seed);
      wrcnt(c, v[15:0]);
      if (c) apb(1'b1, A_T1L, ~v);
      rdcnt(c);
      chk("cnt_off_load", c ? {16'h0, v[15:0]} : {24'h0, v[7:0]}, rd);
    end
    // every prescale step; preload FE gives an overflow each two ticks
    for (i = 0; i < 8; i++) begin
      apb(1'b1, A_C0, 32'h0);
      wrcnt(0, 16'h00FE);
      apb(1'b1, A_C0, 32'h90 | i);
      span(0, n);
      hi[0] = t0_freq_div_out;
      span(0, n);
      chk("t0_span", 2 << i, n);
      chkb("t0_pfd", ~hi[0], t0_freq_div_out);
      apb(1'b0, A_C0, 32'h0);
      chk("t0_ctl_on", 32'h90 | i, rd);
    end
    chkb("t0_flag", 1'b1, t0_overflow_flag);
    apb(1'b1, A_C0, 32'h0);
    apb(1'b1, A_ST, 32'h1);
    chkb("t0_flag_clr", 1'b0, t0_overflow_flag);
    // counter one on clock/4, then on the 32 kHz clock
    apb(1'b1, A_C1, 32'h0);
    wrcnt(1, 16'hFFFE);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, A_C1, i ? 32'hB0 : 32'h90);
      span(1, n);
      hi[0] = t1_freq_div_out;
      span(1, n);
      chkb("t1_pfd", ~hi[0], t1_freq_div_out);
      chkb("t1_span", 1'b1, i ? n inside {[609:612]} : n == 8);
    end
    apb(1'b1, A_C1, 32'h0);
    chkb("t1_flag", 1'b1, t1_overflow_flag);
    apb(1'b1, A_ST, 32'h2);
    chkb("t1_flag_clr", 1'b0, t1_overflow_flag);
    // event mode: n pulses then one rise, counted on the chosen edge
    for (c = 0; c < 2; c++) for (e = 0; e < 2; e++) begin
      apb(1'b1, ca(c), 32'h0);
      pin_u.set_pin(c, 1'b0);
      wrcnt(c, 16'h0);
      n = 1 + {$random(seed)} % 5;
      apb(1'b1, ca(c), 32'h50 | (e << 3));
      repeat (n) pin_u.pulse_hi(c, 0);
      pin_u.set_pin(c, 1'b1);
      repeat (3) @(posedge pclk);
      rdcnt(c);
      chk("evt_cnt", n + (e == 0), rd);
    end
    // pulse width on counter zero: level alone must not start it
    apb(1'b1, A_C0, 32'h0);
    wrcnt(0, 16'h00F0);
    apb(1'b1, A_C0, 32'hD0);
    repeat (20) @(posedge pclk);
    apb(1'b0, A_T0, 32'h0);
    chk("pw_level", 32'hF0, rd);
    pin_u.set_pin(0, 1'b0);
    pin_u.pulse_hi(0, 36);
    repeat (4) @(posedge pclk);
    apb(1'b0, A_T0, 32'h0);
    v = rd;
    chkb("pw_width", 1'b1, rd inside {[32'hF7:32'hF9]});
    chkb("pw_ovf_flag", 1'b1, t0_overflow_flag);
    apb(1'b0, A_C0, 32'h0);
    chk("pw_en_clr", 32'hC0, rd);
    pin_u.pulse_hi(0, 10);
    repeat (4) @(posedge pclk);
    apb(1'b0, A_T0, 32'h0);
    chk("pw_hold", v, rd);
    // reset in mid-run: controls come back off, flags cleared
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_C1, 32'h0);
    chk("c1_rst", 32'h08, rd);
    chkb("flag_rst", 1'b0, t0_overflow_flag);
    complete_run();
  end

  // hang guard, far beyond the few thousand cycles the run needs
  initial begin
    repeat (30000) @(posedge pclk);
    num_errors++;
    complete_run();
  end
endmodule
